// ==== verilog/cst_core.v ====
// core state of the 4-bit controller: program counter, return stack,
// data ram, working registers, nibble ports and single-bit terminals
// assumes one decoded instruction per core_clk edge on op_code/op_arg
`timescale 1ns/1ps

`include "cst_consts.vh"

module cst_core (
   input  wire        core_clk,
   input  wire        srst,
   input  wire [5:0]  op_code,
   input  wire [5:0]  op_arg,
   input  wire [7:0]  pattern_in,
   input  wire [23:0] nib_pins_in,
   input  wire [15:0] bit_pins_in,
   output wire [23:0] nib_pins_out,
   output wire [23:0] nib_pins_oe,
   output wire [3:0]  nibble_output_port,
   output wire [15:0] bit_pins_out,
   output wire [15:0] bit_pins_oe,
   output wire [11:0] prog_counter,
   output wire        bank_select_bit,
   output wire [3:0]  acc,
   output wire        carry_flag,
   output wire        cond_flag,
   output wire        int_enable
);
   // ***************************
   // state
   // ***************************
   reg        bank_q;
   reg [4:0]  page_q;
   reg [5:0]  addr_q;
   reg        pre_valid_q;
   reg [4:0]  pre_page_q;
   reg        skip_next_q;
   reg        int_en_q;
   reg [11:0] return_slot_one_q;
   reg [11:0] return_slot_two_q;
   reg [11:0] return_slot_three_q;
   reg [11:0] return_slot_four_q;
   reg [3:0]  acc_q;
   reg [3:0]  aux_q;
   reg [3:0]  file_idx_q;
   reg [3:0]  digit_idx_q;
   reg [3:0]  file_index_shadow_q;
   reg [3:0]  digit_index_shadow_q;
   reg        carry_q;
   reg        cond_q;
   reg [23:0] nib_port_q;
   reg [23:0] nib_oe_q;
   reg [3:0]  nibble_output_port_q;
   reg        bank_select_bit_q;
   reg [15:0] bit_latch_q;
   reg [15:0] bit_oe_q;
   reg [3:0]  ram_mem [0:255];

   wire [5:0] addr_next;
   wire [11:0] ret_addr;
   wire [7:0] ram_idx;
   wire [7:0] direct_idx;
   wire [3:0] ram_rd;
   wire [3:0] direct_rd;
   wire       cond_pass;
   wire       is_cond_op;
   wire       exec_pre;
   wire       exec_jump;
   wire       exec_call;
   wire       do_int;
   wire       do_push;
   wire       do_pop;
   wire [4:0] adc_sum;
   wire [4:0] imm_sum;
   wire [4:0] y_inc;
   wire [4:0] y_dec;
   wire [1:0] y_step;
   wire       ram_xfer;
   wire       bank_target;
   wire [4:0] page_target;
   reg  [3:0] dst_val;
   reg  [3:0] port_word;

   // ***************************
   // in-page counter
   // ***************************
   cst_poly_step u_poly (
      .cur (addr_q),
      .nxt (addr_next)
   );

   // ***************************
   // decode
   // ***************************
   assign ret_addr   = {bank_q, page_q, addr_next};
   assign ram_idx    = {file_idx_q, digit_idx_q};
   assign direct_idx = {`CST_DIRECT_FILE, op_arg[3:0]};
   // asynchronous array read: old word is seen before the edge writes
   assign ram_rd     = ram_mem[ram_idx];
   assign direct_rd  = ram_mem[direct_idx];

   assign is_cond_op = (op_code == `CST_OP_PRELOAD) |
                       (op_code == `CST_OP_JUMP) |
                       (op_code == `CST_OP_CALL);
   // a skipped preload also skips the jump or call that completes it
   assign cond_pass  = cond_q & ~skip_next_q;
   assign exec_pre   = (op_code == `CST_OP_PRELOAD) & cond_pass;
   assign exec_jump  = (op_code == `CST_OP_JUMP) & cond_pass;
   assign exec_call  = (op_code == `CST_OP_CALL) & cond_pass;
   assign do_int     = (op_code == `CST_OP_INT_ENTRY);
   assign do_push    = exec_call | do_int;
   assign do_pop     = (op_code == `CST_OP_RET) |
                       (op_code == `CST_OP_RETI);

   // without a preload a call lands in bank 0 page 0
   assign bank_target = pre_valid_q ? ~bank_select_bit_q : 1'b0;
   assign page_target = pre_valid_q ? pre_page_q : 5'h00;

   assign adc_sum = {1'b0, acc_q} + {1'b0, ram_rd} + {4'h0, carry_q};
   assign imm_sum = {1'b0, dst_val} + {1'b0, op_arg[3:0]};
   assign y_inc   = {1'b0, digit_idx_q} + 5'h01;
   assign y_dec   = {1'b0, digit_idx_q} - 5'h01;
   assign y_step  = op_arg[1:0];
   assign ram_xfer = (op_code == `CST_OP_RAM_RD) |
                     (op_code == `CST_OP_RAM_WR) |
                     (op_code == `CST_OP_RAM_XCH);

   always @* begin
      case (op_arg[5:4])
         `CST_DST_ACC:   dst_val = acc_q;
         `CST_DST_AUX:   dst_val = aux_q;
         `CST_DST_FILE:  dst_val = file_idx_q;
         `CST_DST_DIGIT: dst_val = digit_idx_q;
         default:        dst_val = acc_q;
      endcase
   end

   // register output and pin level meet as a wired and
   always @* begin
      case (op_arg[2:0])
         3'h0: port_word = nib_port_q[3:0] & nib_pins_in[3:0];
         3'h1: port_word = nib_port_q[7:4] & nib_pins_in[7:4];
         3'h2: port_word = nib_port_q[11:8] & nib_pins_in[11:8];
         3'h3: port_word = nib_port_q[15:12] & nib_pins_in[15:12];
         3'h4: port_word = nib_port_q[19:16] & nib_pins_in[19:16];
         3'h5: port_word = nib_port_q[23:20] & nib_pins_in[23:20];
         default: port_word = nibble_output_port_q;
      endcase
   end

   // ***************************
   // program counter and control flags
   // ***************************
   always @(posedge core_clk) begin
      if (srst) begin
         bank_q      <= `CST_RST_BANK;
         page_q      <= `CST_RST_PAGE;
         addr_q      <= `CST_RST_ADDR;
         pre_valid_q <= 1'b0;
         pre_page_q  <= 5'h00;
         skip_next_q <= 1'b0;
         int_en_q    <= 1'b0;
      end else begin
         addr_q <= addr_next;
         if (is_cond_op) begin
            skip_next_q <= (op_code == `CST_OP_PRELOAD) & ~cond_pass;
         end else begin
            skip_next_q <= 1'b0;
         end
         if (exec_pre) begin
            pre_valid_q <= 1'b1;
            pre_page_q  <= op_arg[4:0];
         end else if (is_cond_op | do_int | do_pop) begin
            pre_valid_q <= 1'b0;
         end
         if (exec_jump) begin
            addr_q <= op_arg;
            if (pre_valid_q) begin
               bank_q <= ~bank_select_bit_q;
               page_q <= pre_page_q;
            end
         end else if (exec_call) begin
            bank_q <= bank_target;
            page_q <= page_target;
            addr_q <= op_arg;
         end else if (do_int) begin
            bank_q   <= 1'b0;
            page_q   <= {4'h0, op_arg[0]};
            addr_q   <= `CST_INT_ADDR;
            int_en_q <= 1'b0;
         end else if (do_pop) begin
            bank_q <= return_slot_one_q[11];
            page_q <= return_slot_one_q[10:6];
            addr_q <= return_slot_one_q[5:0];
            if (op_code == `CST_OP_RETI) begin
               int_en_q <= 1'b1;
            end
         end
      end
   end

   // ***************************
   // return stack, working registers and flags (no reset)
   // ***************************
   always @(posedge core_clk) begin
      if (do_push) begin
         // slot four falls off the end without any error
         return_slot_four_q  <= return_slot_three_q;
         return_slot_three_q <= return_slot_two_q;
         return_slot_two_q   <= return_slot_one_q;
         // interrupt saves the address that was not yet executed
         return_slot_one_q   <= do_int ? {bank_q, page_q, addr_q}
                                       : ret_addr;
      end else if (do_pop) begin
         return_slot_one_q   <= return_slot_two_q;
         return_slot_two_q   <= return_slot_three_q;
         return_slot_three_q <= return_slot_four_q;
      end

      if (is_cond_op & ~cond_pass) begin
         cond_q <= 1'b1;
      end

      case (op_code)
         `CST_OP_ADC_RAM: begin
            acc_q   <= adc_sum[3:0];
            carry_q <= adc_sum[4];
            cond_q  <= adc_sum[4];
         end
         `CST_OP_ADD_IMM: begin
            case (op_arg[5:4])
               `CST_DST_ACC:   acc_q       <= imm_sum[3:0];
               `CST_DST_AUX:   aux_q       <= imm_sum[3:0];
               `CST_DST_FILE:  file_idx_q  <= imm_sum[3:0];
               default:        digit_idx_q <= imm_sum[3:0];
            endcase
            cond_q <= imm_sum[4];
         end
         `CST_OP_AND_RAM: begin
            acc_q  <= acc_q & ram_rd;
            cond_q <= |(acc_q & ram_rd);
         end
         `CST_OP_LOAD_IMM: begin
            case (op_arg[5:4])
               `CST_DST_ACC:   acc_q       <= op_arg[3:0];
               `CST_DST_AUX:   aux_q       <= op_arg[3:0];
               `CST_DST_FILE:  file_idx_q  <= op_arg[3:0];
               default:        digit_idx_q <= op_arg[3:0];
            endcase
         end
         `CST_OP_SET_C:  carry_q <= 1'b1;
         `CST_OP_CLR_C:  carry_q <= 1'b0;
         `CST_OP_TEST_C: cond_q  <= carry_q;
         `CST_OP_ROT_L: begin
            {carry_q, acc_q} <= {acc_q, carry_q};
         end
         `CST_OP_ROT_R: begin
            {acc_q, carry_q} <= {carry_q, acc_q};
         end
         `CST_OP_XCH_X: begin
            file_idx_q          <= file_index_shadow_q;
            file_index_shadow_q <= file_idx_q;
         end
         `CST_OP_XCH_Y: begin
            digit_idx_q          <= digit_index_shadow_q;
            digit_index_shadow_q <= digit_idx_q;
         end
         `CST_OP_RAM_RD: acc_q <= ram_rd;
         `CST_OP_RAM_XCH: acc_q <= ram_rd;
         `CST_OP_XCH_DIRECT: acc_q <= direct_rd;
         `CST_OP_BIT_TEST: cond_q <= ram_rd[op_arg[1:0]];
         `CST_OP_PORT_IN_A: acc_q <= port_word;
         `CST_OP_PORT_IN_B: aux_q <= port_word;
         `CST_OP_DPIN_TEST: cond_q <= bit_pins_in[digit_idx_q];
         default: begin
         end
      endcase

      // digit index steps alongside the data move
      if (ram_xfer & (y_step == `CST_YSTEP_INC)) begin
         digit_idx_q <= y_inc[3:0];
         cond_q      <= ~y_inc[4];
      end else if (ram_xfer & (y_step == `CST_YSTEP_DEC)) begin
         digit_idx_q <= y_dec[3:0];
         cond_q      <= ~y_dec[4];
      end
   end

   // ***************************
   // data ram writes
   // ***************************
   always @(posedge core_clk) begin
      case (op_code)
         `CST_OP_RAM_WR:     ram_mem[ram_idx] <= acc_q;
         `CST_OP_RAM_XCH:    ram_mem[ram_idx] <= acc_q;
         `CST_OP_XCH_DIRECT: ram_mem[direct_idx] <= acc_q;
         `CST_OP_BIT_SET: begin
            ram_mem[ram_idx] <= ram_rd | (4'h1 << op_arg[1:0]);
         end
         `CST_OP_BIT_CLR: begin
            ram_mem[ram_idx] <= ram_rd & ~(4'h1 << op_arg[1:0]);
         end
         default: begin
         end
      endcase
   end

   // ***************************
   // nibble ports and single-bit terminals
   // ***************************
   // pins are open drain: a zero in a register pulls low, a one releases
   always @(posedge core_clk) begin
      if (srst) begin
         nib_port_q           <= `CST_RST_NIB_PORTS;
         nib_oe_q             <= ~`CST_RST_NIB_PORTS;
         nibble_output_port_q <= `CST_RST_OUT_PORT;
         bank_select_bit_q    <= `CST_RST_BANK_SEL;
         bit_latch_q          <= `CST_RST_BIT_LATCH;
         bit_oe_q             <= ~`CST_RST_BIT_LATCH;
      end else begin
         if ((op_code == `CST_OP_PORT_OUT_A) |
             (op_code == `CST_OP_PORT_OUT_B)) begin
            case (op_arg[2:0])
               `CST_PORT_OUT_ONLY: begin
                  nibble_output_port_q <= (op_code == `CST_OP_PORT_OUT_A)
                                          ? acc_q : aux_q;
               end
               `CST_PORT_BANK: begin
                  bank_select_bit_q <= (op_code == `CST_OP_PORT_OUT_A)
                                       ? acc_q[0] : aux_q[0];
               end
               default: begin
                  nib_port_q[{op_arg[2:0], 2'h0} +: 4] <=
                     (op_code == `CST_OP_PORT_OUT_A) ? acc_q : aux_q;
                  nib_oe_q[{op_arg[2:0], 2'h0} +: 4] <=
                     (op_code == `CST_OP_PORT_OUT_A) ? ~acc_q : ~aux_q;
               end
            endcase
         end else if (op_code == `CST_OP_PATTERN) begin
            nib_port_q[11:8]  <= pattern_in[7:4];
            nib_port_q[15:12] <= pattern_in[3:0];
            nib_oe_q[11:8]    <= ~pattern_in[7:4];
            nib_oe_q[15:12]   <= ~pattern_in[3:0];
         end

         // the terminal is picked by the digit index or, for 0-3, directly
         case (op_code)
            `CST_OP_DPIN_SET: begin
               bit_latch_q[digit_idx_q] <= 1'b1;
               bit_oe_q[digit_idx_q]    <= 1'b0;
            end
            `CST_OP_DPIN_CLR: begin
               bit_latch_q[digit_idx_q] <= 1'b0;
               bit_oe_q[digit_idx_q]    <= 1'b1;
            end
            `CST_OP_DPIN_SET_N: begin
               bit_latch_q[op_arg[1:0]] <= 1'b1;
               bit_oe_q[op_arg[1:0]]    <= 1'b0;
            end
            `CST_OP_DPIN_CLR_N: begin
               bit_latch_q[op_arg[1:0]] <= 1'b0;
               bit_oe_q[op_arg[1:0]]    <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // ***************************
   // outputs
   // ***************************
   assign nib_pins_out       = nib_port_q;
   assign nib_pins_oe        = nib_oe_q;
   assign nibble_output_port = nibble_output_port_q;
   assign bit_pins_out       = bit_latch_q;
   assign bit_pins_oe        = bit_oe_q;
   assign prog_counter       = {bank_q, page_q, addr_q};
   assign bank_select_bit    = bank_select_bit_q;
   assign acc                = acc_q;
   assign carry_flag         = carry_q;
   assign cond_flag          = cond_q;
   assign int_enable         = int_en_q;
endmodule

// ==== verilog/cst_consts.vh ====
// constants shared by the call stack, ram and port core
// assumes inclusion by bare name from the design files
`ifndef CST_CONSTS_VH
`define CST_CONSTS_VH

// ***************************
// instruction codes
// ***************************
`define CST_OP_NOP        6'h00
`define CST_OP_PRELOAD    6'h01
`define CST_OP_JUMP       6'h02
`define CST_OP_CALL       6'h03
`define CST_OP_RET        6'h04
`define CST_OP_RETI       6'h05
`define CST_OP_INT_ENTRY  6'h06
`define CST_OP_ADC_RAM    6'h07
`define CST_OP_ADD_IMM    6'h08
`define CST_OP_AND_RAM    6'h09
`define CST_OP_LOAD_IMM   6'h0A
`define CST_OP_SET_C      6'h0B
`define CST_OP_CLR_C      6'h0C
`define CST_OP_TEST_C     6'h0D
`define CST_OP_ROT_L      6'h0E
`define CST_OP_ROT_R      6'h0F
`define CST_OP_XCH_X      6'h10
`define CST_OP_XCH_Y      6'h11
`define CST_OP_RAM_RD     6'h12
`define CST_OP_RAM_WR     6'h13
`define CST_OP_RAM_XCH    6'h14
`define CST_OP_XCH_DIRECT 6'h15
`define CST_OP_BIT_SET    6'h16
`define CST_OP_BIT_CLR    6'h17
`define CST_OP_BIT_TEST   6'h18
`define CST_OP_PORT_OUT_A 6'h19
`define CST_OP_PORT_OUT_B 6'h1A
`define CST_OP_PORT_IN_A  6'h1B
`define CST_OP_PORT_IN_B  6'h1C
`define CST_OP_PATTERN    6'h1D
`define CST_OP_DPIN_SET   6'h1E
`define CST_OP_DPIN_CLR   6'h1F
`define CST_OP_DPIN_TEST  6'h20
`define CST_OP_DPIN_SET_N 6'h21
`define CST_OP_DPIN_CLR_N 6'h22

// ***************************
// operand fields
// ***************************
`define CST_DST_ACC       2'h0
`define CST_DST_AUX       2'h1
`define CST_DST_FILE      2'h2
`define CST_DST_DIGIT     2'h3
`define CST_YSTEP_NONE    2'h0
`define CST_YSTEP_INC     2'h1
`define CST_YSTEP_DEC     2'h2
`define CST_PORT_OUT_ONLY 3'h6
`define CST_PORT_BANK     3'h7
`define CST_DIRECT_FILE   4'hF

// ***************************
// reset values and fixed addresses
// ***************************
`define CST_RST_BANK      1'h1
`define CST_RST_PAGE      5'h1F
`define CST_RST_ADDR      6'h3F
`define CST_RST_NIB_PORTS 24'hFFFFFF
`define CST_RST_OUT_PORT  4'hF
`define CST_RST_BIT_LATCH 16'hFFFF
`define CST_RST_BANK_SEL  1'h1
`define CST_INT_ADDR      6'h3F
// feedback bit of the in-page counter, indexed by the present count
`define CST_POLY_FB       64'h7FFF00008000FFFF

`endif

// ==== verilog/cst_poly_step.v ====
// next state of the 6-bit in-page polynomial counter
// assumes a purely combinational use by the core
`timescale 1ns/1ps

`include "cst_consts.vh"

module cst_poly_step (
   input  wire [5:0] cur,
   output wire [5:0] nxt
);
   wire [63:0] fb_table;

   // shift left, new low bit from the feedback table; all 64 values cycle
   assign fb_table = `CST_POLY_FB;
   assign nxt      = {cur[4:0], fb_table[cur]};
endmodule

// ==== sim/cst_core_props.sv ====
// port assertions for cst_core, one instruction per clock edge
// assumes it is bound into the core by the bench
`timescale 1ns/1ps
`include "cst_consts.vh"
module cst_core_props (
   input wire        core_clk,
   input wire        srst,
   input wire [5:0]  op_code,
   input wire [5:0]  op_arg,
   input wire [23:0] nib_pins_out,
   input wire [23:0] nib_pins_oe,
   input wire [15:0] bit_pins_out,
   input wire [11:0] prog_counter,
   input wire        bank_select_bit,
   input wire [3:0]  acc,
   input wire        carry_flag,
   input wire        cond_flag,
   input wire        int_enable
);
   localparam [63:0] FB = `CST_POLY_FB;
   reg       pre_q;
   reg       armed_q;
   reg [4:0] page_q;
   // a preload, run or skipped, decides the form of the next call
   always @(posedge core_clk) begin
      pre_q  <= op_code == `CST_OP_PRELOAD;
      page_q <= op_arg[4:0];
   end
   // a preload stays armed across other ops until a transfer op
   always @(posedge core_clk) begin
      if (srst) begin
         armed_q <= 1'b0;
      end else if (op_code == `CST_OP_PRELOAD) begin
         armed_q <= 1'b1;
      end else if (op_code == `CST_OP_JUMP || op_code == `CST_OP_CALL ||
         op_code == `CST_OP_RET || op_code == `CST_OP_RETI ||
         op_code == `CST_OP_INT_ENTRY) begin
         armed_q <= 1'b0;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   a_reset_vals: assert property (disable iff (1'b0) srst |=>
      nib_pins_out == 24'hFFFFFF && bit_pins_out == 16'hFFFF &&
      bank_select_bit) else $error("reset values wrong");
   a_call_near: assert property (!armed_q && op_code == `CST_OP_CALL &&
      cond_flag |=> prog_counter == {6'h00, $past(op_arg)})
      else $error("call target wrong");
   a_call_far: assert property (pre_q && $past(cond_flag) && cond_flag
      && op_code == `CST_OP_CALL |=> prog_counter ==
      {!$past(bank_select_bit), $past(page_q), $past(op_arg)})
      else $error("far call target wrong");
   a_skip_flag: assert property (!cond_flag && (op_code == `CST_OP_CALL
      || op_code == `CST_OP_JUMP || op_code == `CST_OP_PRELOAD) |=>
      cond_flag && $stable(prog_counter[11:6])) else $error("skip wrong");
   a_poly_step: assert property (op_code == `CST_OP_NOP |=>
      prog_counter == {$past(prog_counter[11:6]),
      $past(prog_counter[4:0]), FB[$past(prog_counter[5:0])]})
      else $error("pc step wrong");
   a_int_entry: assert property (op_code == `CST_OP_INT_ENTRY |=>
      prog_counter == {5'h00, $past(op_arg[0]), 6'h3F} && !int_enable)
      else $error("interrupt entry wrong");
   a_port_write: assert property (op_code == `CST_OP_PORT_OUT_A &&
      op_arg[2:0] < 3'h6 |=> nib_pins_out[$past(op_arg[2:0]) * 4 +: 4]
      == $past(acc) && nib_pins_oe == ~nib_pins_out)
      else $error("port write wrong");
   a_bit_direct: assert property ((op_code == `CST_OP_DPIN_SET_N ||
      op_code == `CST_OP_DPIN_CLR_N) && op_arg[5:2] == 4'h0 |=>
      bit_pins_out[$past(op_arg[1:0])] == ($past(op_code) ==
      `CST_OP_DPIN_SET_N)) else $error("direct terminal wrong");
   a_rotate_left: assert property (op_code == `CST_OP_ROT_L |=>
      {carry_flag, acc} == {$past(acc), $past(carry_flag)})
      else $error("rotate left wrong");
   c_far_call: cover property (pre_q && op_code == `CST_OP_CALL);
   c_skip: cover property (!cond_flag && op_code == `CST_OP_CALL);
   c_int: cover property (op_code == `CST_OP_INT_ENTRY);
endmodule

// ==== sim/cst_pins_model.sv ====
// outside circuitry on the open-drain ports and terminals
// assumes oe high means the core pulls the line low
`timescale 1ns/1ps
module cst_pins_model (
   input  wire [23:0] nib_pins_oe,
   input  wire [15:0] bit_pins_oe,
   input  wire [23:0] nib_pull_low,
   input  wire [15:0] bit_pull_low,
   output wire [23:0] nib_pins_in,
   output wire [15:0] bit_pins_in
);
   // pulled-up lines: outside drivers may only pull low, never high
   assign nib_pins_in = ~(nib_pins_oe | nib_pull_low);
   assign bit_pins_in = ~(bit_pins_oe | bit_pull_low);
endmodule

// ==== sim/cst_core_test.sv ====
// self-checking bench for cst_core, one op driven per falling edge
// assumes the pin model closes the open-drain lines
`timescale 1ns/1ps
`include "cst_consts.vh"
module cst_core_test;
   reg         core_clk;
   reg         srst;
   reg  [5:0]  op_code;
   reg  [5:0]  op_arg;
   reg  [7:0]  pattern_in;
   reg  [23:0] nib_pull_low;
   reg  [15:0] bit_pull_low;
   wire [23:0] nib_pins_in;
   wire [23:0] nib_pins_out;
   wire [23:0] nib_pins_oe;
   wire [3:0]  nibble_output_port;
   wire [15:0] bit_pins_in;
   wire [15:0] bit_pins_out;
   wire [15:0] bit_pins_oe;
   wire [11:0] prog_counter;
   wire        bank_select_bit;
   wire [3:0]  acc;
   wire        carry_flag;
   wire        cond_flag;
   wire        int_enable;
   integer     errors;
   integer     checks;
   reg  [11:0] pc_at;
   reg  [11:0] rets [0:4];
   cst_core i_dut (.core_clk, .srst, .op_code, .op_arg, .pattern_in,
      .nib_pins_in, .bit_pins_in, .nib_pins_out, .nib_pins_oe,
      .nibble_output_port, .bit_pins_out, .bit_pins_oe, .prog_counter,
      .bank_select_bit, .acc, .carry_flag, .cond_flag, .int_enable);
   cst_pins_model i_pins (.nib_pins_oe, .bit_pins_oe, .nib_pull_low,
      .bit_pull_low, .nib_pins_in, .bit_pins_in);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function [5:0] step6(input [5:0] c);
      reg [63:0] fb;
      begin
         fb = `CST_POLY_FB;
         step6 = {c[4:0], fb[c]};
      end
   endfunction
   task chk(input string what, input [23:0] exp, input [23:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task ex(input [5:0] op, input [5:0] arg);
      begin
         @(negedge core_clk);
         pc_at = prog_counter;
         op_code = op;
         op_arg = arg;
      end
   endtask
   // outputs are judged one nop later, once the previous op has landed
   task nop;
      ex(`CST_OP_NOP, 6'h00);
   endtask
   task ld(input [1:0] dst, input [3:0] v);
      ex(`CST_OP_LOAD_IMM, {dst, v});
   endtask
   task setc(input v);
      begin
         ex(v ? `CST_OP_SET_C : `CST_OP_CLR_C, 6'h00);
         ex(`CST_OP_TEST_C, 6'h00);
      end
   endtask
   // ***************************
   // scenarios
   // ***************************
   task t_stack;
      integer i;
      begin
         setc(1'b1);
         for (i = 0; i < 5; i = i + 1) begin
            ex(`CST_OP_CALL, 6'h10 + i[5:0]);
            rets[i] = {pc_at[11:6], step6(pc_at[5:0])};
            nop;
            chk("call pc", {6'h00, 6'h10 + i[5:0]}, prog_counter);
         end
         // five deep: the oldest return is gone, four remain
         for (i = 4; i > 0; i = i - 1) begin
            ex(`CST_OP_RET, 6'h00);
            nop;
            chk("return pc", rets[i], prog_counter);
         end
      end
   endtask
   task far(input b, input [4:0] pg, input [5:0] a);
      begin
         ld(`CST_DST_ACC, {4{b}});
         ex(`CST_OP_PORT_OUT_A, 6'h07);
         ex(`CST_OP_PRELOAD, {1'b0, pg});
         ex(`CST_OP_CALL, a);
         nop;
         chk("far call", {!b, pg, a}, prog_counter);
      end
   endtask
   task t_skip;
      reg [5:0] pg;
      begin
         setc(1'b0);
         ex(`CST_OP_CALL, 6'h21);
         pg = pc_at[11:6];
         nop;
         chk("skipped call", pg, prog_counter[11:6]);
         chk("flag after skip", 24'h000001, cond_flag);
         setc(1'b0);
         ex(`CST_OP_PRELOAD, 6'h03);
         ex(`CST_OP_CALL, 6'h21);
         pg = pc_at[11:6];
         nop;
         chk("call after skip", pg, prog_counter[11:6]);
         ex(`CST_OP_JUMP, 6'h2A);
         pg = pc_at[11:6];
         nop;
         chk("jump", {pg, 6'h2A}, prog_counter);
         far(1'b0, 5'h0A, 6'h2E);
         far(1'b1, 5'h05, 6'h3F);
      end
   endtask
   task t_int;
      reg [11:0] back;
      begin
         ex(`CST_OP_INT_ENTRY, 6'h01);
         back = pc_at;
         nop;
         chk("int pc", 24'h00007F, prog_counter);
         chk("int enable", 24'h000000, int_enable);
         ex(`CST_OP_RETI, 6'h00);
         nop;
         chk("reti pc", back, prog_counter);
         chk("reti enable", 24'h000001, int_enable);
      end
   endtask
   task t_ram;
      begin
         ld(`CST_DST_FILE, 4'h3);
         ld(`CST_DST_DIGIT, 4'h5);
         ld(`CST_DST_ACC, 4'h9);
         ex(`CST_OP_RAM_WR, 6'h00);
         ld(`CST_DST_ACC, 4'h6);
         ex(`CST_OP_RAM_XCH, 6'h00);
         ex(`CST_OP_BIT_TEST, 6'h01);
         nop;
         chk("xch old word", 24'h000009, acc);
         chk("bit test", 24'h000001, cond_flag);
         ex(`CST_OP_BIT_CLR, 6'h02);
         ex(`CST_OP_BIT_SET, 6'h00);
         ex(`CST_OP_RAM_RD, 6'h01);
         ld(`CST_DST_ACC, 4'hC);
         ex(`CST_OP_RAM_WR, 6'h02);
         ex(`CST_OP_RAM_RD, 6'h01);
         nop;
         chk("bit ops", 24'h000003, acc);
         ex(`CST_OP_RAM_RD, 6'h00);
         nop;
         chk("stepped digit", 24'h00000C, acc);
         ld(`CST_DST_ACC, 4'hA);
         ex(`CST_OP_XCH_DIRECT, 6'h06);
         ld(`CST_DST_FILE, 4'hF);
         ex(`CST_OP_RAM_RD, 6'h00);
         nop;
         chk("direct word", 24'h00000A, acc);
      end
   endtask
   task t_alu;
      begin
         ld(`CST_DST_ACC, 4'h9);
         setc(1'b0);
         ex(`CST_OP_ADD_IMM, {`CST_DST_ACC, 4'h8});
         nop;
         chk("add", 24'h000011, {carry_flag, 3'h0, cond_flag, acc});
         ex(`CST_OP_SET_C, 6'h00);
         ld(`CST_DST_ACC, 4'h8);
         ex(`CST_OP_ROT_L, 6'h00);
         nop;
         chk("rotate", 24'h000011, {carry_flag, acc});
         ex(`CST_OP_ADC_RAM, 6'h00);
         nop;
         chk("adc", 24'h00000C, {carry_flag, cond_flag, acc});
      end
   endtask
   task t_ports;
      begin
         ld(`CST_DST_ACC, 4'h7);
         ex(`CST_OP_PORT_OUT_A, 6'h02);
         ld(`CST_DST_ACC, 4'h5);
         ex(`CST_OP_PORT_OUT_A, 6'h06);
         nib_pull_low = 24'h000200;
         ex(`CST_OP_PORT_IN_A, 6'h02);
         nop;
         nib_pull_low = 24'h000000;
         chk("port 2", 24'h000087, {nib_pins_oe[11:8], nib_pins_out[11:8]});
         chk("out port", 24'h000005, nibble_output_port);
         chk("wired in", 24'h000005, acc);
         pattern_in = 8'h4B;
         ex(`CST_OP_PATTERN, 6'h00);
         nop;
         chk("pattern", 24'h0000B4, nib_pins_out[15:8]);
      end
   endtask
   task t_bits;
      begin
         ld(`CST_DST_DIGIT, 4'h9);
         ex(`CST_OP_DPIN_CLR, 6'h00);
         nop;
         chk("terminal clear", 24'h00FDFF, bit_pins_out);
         chk("terminal oe", 24'h000200, bit_pins_oe);
         ex(`CST_OP_DPIN_SET, 6'h00);
         bit_pull_low = 16'h0200;
         ex(`CST_OP_DPIN_TEST, 6'h00);
         nop;
         bit_pull_low = 16'h0000;
         chk("terminal test", 24'h000000, cond_flag);
         ex(`CST_OP_DPIN_CLR_N, 6'h02);
         nop;
         chk("direct clear", 24'h00FFFB, bit_pins_out);
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d errors %0d", checks, errors);
         if (errors == 0 && checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      errors = 0;
      checks = 0;
      srst = 1'b1;
      op_code = 6'h00;
      op_arg = 6'h00;
      pattern_in = 8'h00;
      nib_pull_low = 24'h000000;
      bit_pull_low = 16'h0000;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      chk("reset pc", 24'h000FFF, prog_counter);
      t_stack;
      t_skip;
      t_int;
      t_ram;
      t_alu;
      t_ports;
      t_bits;
      print_verdict;
   end
endmodule
bind cst_core cst_core_props i_props (.core_clk, .srst, .op_code, .op_arg,
   .nib_pins_out, .nib_pins_oe, .bit_pins_out, .prog_counter,
   .bank_select_bit, .acc, .carry_flag, .cond_flag, .int_enable);
